// ### shared/scan_pkg.sv
package scan_pkg;

	localparam int DATA_W = 16;
	localparam int CHAN_W = 4;
	localparam int GAIN_W = 3;
	localparam int TAB_AW = 9;
	localparam int BUF_AW = 10;
	localparam logic [BUF_AW:0] BUF_DEPTH = 11'h400;
	localparam logic [1:0] STATUS_IDLE = 2'h0;
	localparam logic [1:0] STATUS_DONE = 2'h1;
	localparam logic [1:0] SUB_LAST = 2'h3;
	localparam logic PIN_IDLE_LEVEL = 1'b1;
	localparam logic [15:0] DIV_RESET = 16'h0000;

	typedef struct packed {
		logic [CHAN_W-1:0] chan;
		logic [GAIN_W-1:0] gain;
	} table_entry_s;

endpackage

// ### shared/ram_if.sv
interface ram_if #(
	parameter int AW = 4,
	parameter int DW = 8
) (
	input wire logic clk
);
	logic we;
	logic [AW-1:0] waddr;
	logic [DW-1:0] wdata;
	logic [AW-1:0] raddr;
	logic [DW-1:0] rdata;

	modport owner(output we, output waddr, output wdata, output raddr, input rdata);
	modport store(input clk, input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ### verilog/seq_ram.sv
module seq_ram #(
	parameter int AW = 4,
	parameter int DW = 8
) (
	ram_if.store port
);
	logic [DW-1:0] mem [2**AW];
	logic [DW-1:0] rd_q;

	// Read data always leaves through a register
	always_ff @(posedge port.clk) begin
		if (port.we) begin
			mem[port.waddr] <= port.wdata;
		end
		rd_q <= mem[port.raddr];
	end

	assign port.rdata = rd_q;
endmodule

// ### verilog/pin_edge_sync.sv
module pin_edge_sync import scan_pkg::*; (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic pin_n,
	output logic fall
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} sync_s;

	sync_s q;
	sync_s d;

	always_comb begin
		d = q;
		d.s1 = pin_n;
		d.s2 = q.s1;
		d.s3 = q.s2;
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			q <= '{PIN_IDLE_LEVEL, PIN_IDLE_LEVEL, PIN_IDLE_LEVEL};
		end else begin
			q <= d;
		end
	end

	// High-to-low edge seen on the synchronised level
	assign fall = q.s3 & ~q.s2;
endmodule

// ### verilog/scan_sequencer.sv
module scan_sequencer import scan_pkg::*; (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic tbl_we,
	input wire logic [TAB_AW-1:0] tbl_addr,
	input wire logic [CHAN_W-1:0] tbl_chan,
	input wire logic [GAIN_W-1:0] tbl_gain,
	input wire logic [TAB_AW:0] scan_length,
	input wire logic [2:0] expander_board_count,
	input wire logic ring_mode,
	input wire logic continuous,
	input wire logic ext_trig_en,
	input wire logic ext_conv_en,
	input wire logic analog_trig_en,
	input wire logic trig_rising,
	input wire logic pretrig_en,
	input wire logic [CHAN_W-1:0] trig_chan,
	input wire logic [DATA_W-1:0] trig_level,
	input wire logic [31:0] sample_count,
	input wire logic [BUF_AW:0] block_len,
	input wire logic [15:0] post_count,
	input wire logic [15:0] sample_interval,
	input wire logic scan_start,
	input wire logic acquisition_abort,
	input wire logic ring_acquisition_abort,
	input wire logic block_fetch,
	input wire logic [BUF_AW:0] fetch_len,
	input wire logic start_trigger_n,
	input wire logic stop_trigger_n,
	input wire logic ext_convert_n,
	input wire logic conv_done,
	input wire logic [DATA_W-1:0] conv_data,
	output logic conv_start,
	output logic [CHAN_W-1:0] mux_chan,
	output logic [GAIN_W-1:0] mux_gain,
	output logic [3:0] expander_sel,
	output logic busy,
	output logic [1:0] status,
	output logic overrun,
	output logic start_refused,
	output logic fetch_refused,
	output logic [BUF_AW:0] fill_level,
	output logic fetch_valid,
	output logic [DATA_W-1:0] fetch_data
);
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_WAIT = 4'h2,
		ST_RUN = 4'h4,
		ST_POST = 4'h8
	} acq_state_e;

	typedef struct packed {
		acq_state_e st;
		logic [TAB_AW-1:0] ptr;
		logic [1:0] sub;
		logic [1:0] board;
		logic fresh;
		logic [15:0] div;
		logic pend;
		logic conv;
		logic [BUF_AW-1:0] wr;
		logic [BUF_AW-1:0] rd;
		logic [BUF_AW:0] level;
		logic [31:0] total;
		logic [BUF_AW:0] blk;
		logic [15:0] post;
		logic [DATA_W-1:0] prev;
		logic prev_ok;
		logic busy;
		logic [1:0] status;
		logic overrun;
		logic refused;
		logic fetch_refused;
		logic [BUF_AW:0] left;
		logic rvalid;
	} seq_state_s;

	seq_state_s q;
	seq_state_s d;
	logic start_fall;
	logic stop_fall;
	logic conv_fall;
	logic store;
	table_entry_s entry;

	////////////////////////////////////////////////////////////////////////
	// Pins and memories

	pin_edge_sync u_start (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.pin_n(start_trigger_n),
		.fall(start_fall)
	);

	pin_edge_sync u_stop (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.pin_n(stop_trigger_n),
		.fall(stop_fall)
	);

	pin_edge_sync u_conv (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.pin_n(ext_convert_n),
		.fall(conv_fall)
	);

	ram_if #(.AW(TAB_AW), .DW(CHAN_W + GAIN_W)) tab (.clk(ref_clk));
	ram_if #(.AW(BUF_AW), .DW(DATA_W)) smp (.clk(ref_clk));

	seq_ram #(.AW(TAB_AW), .DW(CHAN_W + GAIN_W)) u_tab (.port(tab.store));
	seq_ram #(.AW(BUF_AW), .DW(DATA_W)) u_smp (.port(smp.store));

	// Table holds its contents until the host rewrites an entry
	assign tab.we = tbl_we;
	assign tab.waddr = tbl_addr;
	assign tab.wdata = {tbl_chan, tbl_gain};
	assign tab.raddr = q.ptr;
	assign entry = tab.rdata;

	assign smp.we = store;
	assign smp.waddr = q.wr;
	assign smp.wdata = conv_data;
	assign smp.raddr = q.rd;

	////////////////////////////////////////////////////////////////////////
	// Sequencer

	always_comb begin
		logic active;
		logic tick;
		logic hit;
		logic last_entry;
		logic last_sub;
		logic rd_fetch;
		logic full;
		logic abort;
		active = 1'b0;
		tick = 1'b0;
		hit = 1'b0;
		last_entry = 1'b0;
		last_sub = 1'b0;
		rd_fetch = 1'b0;
		full = 1'b0;
		abort = acquisition_abort | ring_acquisition_abort;
		store = 1'b0;
		d = q;
		d.conv = 1'b0;
		d.refused = 1'b0;
		d.fetch_refused = 1'b0;
		d.rvalid = 1'b0;
		d.fresh = 1'b1;

		// Conversion pacing: external pulse or internal interval
		active = (q.st == ST_RUN) || (q.st == ST_POST) || ((q.st == ST_WAIT) && analog_trig_en);
		if (ext_conv_en) begin
			tick = conv_fall;
		end else begin
			tick = (q.div == 16'h0000);
			d.div = tick ? 16'(sample_interval - 16'h0001) : 16'(q.div - 16'h0001);
		end
		if (active && tick && !q.pend && q.fresh) begin
			d.conv = 1'b1;
			d.pend = 1'b1;
		end

		// Block readout runs alongside acquisition
		rd_fetch = (q.left != '0);
		if (rd_fetch) begin
			d.rd = BUF_AW'(q.rd + 1'b1);
			d.left = (BUF_AW + 1)'(q.left - 1'b1);
			d.rvalid = 1'b1;
		end
		if (block_fetch) begin
			if (!rd_fetch && (fetch_len != '0) && (fetch_len <= q.level)) begin
				d.left = fetch_len;
			end else begin
				d.fetch_refused = 1'b1;
			end
		end
		d.level = (BUF_AW + 1)'(q.level - (rd_fetch ? 1'b1 : 1'b0));

		if (q.pend && conv_done && active) begin
			d.pend = 1'b0;
			d.fresh = 1'b0;
			// Step sub-channel and expander board before the table entry
			last_sub = (expander_board_count == 3'h0) ||
				((q.sub == SUB_LAST) && (q.board == 2'(expander_board_count - 3'h1)));
			last_entry = (q.ptr == TAB_AW'(scan_length - 10'h1));
			if (expander_board_count != 3'h0) begin
				d.sub = 2'(q.sub + 2'h1);
				if (q.sub == SUB_LAST) begin
					d.board = last_sub ? 2'h0 : 2'(q.board + 2'h1);
				end
			end
			if (last_sub) begin
				d.ptr = last_entry ? '0 : TAB_AW'(q.ptr + 1'b1);
			end

			if (q.st == ST_WAIT) begin
				if (entry.chan == trig_chan) begin
					d.prev = conv_data;
					d.prev_ok = 1'b1;
					if (trig_rising) begin
						hit = q.prev_ok && ($signed(q.prev) < $signed(trig_level)) &&
							($signed(conv_data) >= $signed(trig_level));
					end else begin
						hit = q.prev_ok && ($signed(q.prev) > $signed(trig_level)) &&
							($signed(conv_data) <= $signed(trig_level));
					end
				end
				if (hit) begin
					d.st = ST_RUN;
					d.ptr = '0;
					d.sub = 2'h0;
					d.board = 2'h0;
					d.prev_ok = 1'b0;
				end
			end else begin
				store = 1'b1;
				d.wr = BUF_AW'(q.wr + 1'b1);
				d.total = 32'(q.total + 32'h1);
				d.blk = (BUF_AW + 1)'(q.blk + 1'b1);
				full = (q.level == BUF_DEPTH) && !rd_fetch;
				if (full) begin
					// Writer overtakes the oldest unread word
					d.rd = BUF_AW'(q.rd + 1'b1);
					d.overrun = q.overrun | ring_mode;
				end else begin
					d.level = (BUF_AW + 1)'(d.level + 1'b1);
				end
				if (q.st == ST_POST) begin
					d.post = 16'(q.post - 16'h0001);
					if (q.post == 16'h0001) begin
						d.st = ST_IDLE;
						d.status = STATUS_DONE;
					end
				end else if (ring_mode) begin
					if (!continuous && (q.total == 32'(sample_count - 32'h1))) begin
						d.st = ST_IDLE;
						d.status = STATUS_DONE;
					end else if (q.blk == (BUF_AW + 1)'(block_len - 1'b1)) begin
						d.blk = '0;
						// Software trigger restarts at once; otherwise wait again
						d.st = (ext_trig_en || analog_trig_en) ? ST_WAIT : ST_RUN;
						d.prev_ok = 1'b0;
					end
				end else if (!pretrig_en && (q.total == 32'(sample_count - 32'h1))) begin
					d.st = ST_IDLE;
					d.status = STATUS_DONE;
				end
			end
		end

		// Stop trigger opens the post-trigger count
		if ((q.st == ST_RUN) && pretrig_en && !ring_mode && stop_fall) begin
			if (post_count == 16'h0000) begin
				d.st = ST_IDLE;
				d.status = STATUS_DONE;
			end else begin
				d.st = ST_POST;
				d.post = post_count;
			end
		end

		if ((q.st == ST_WAIT) && ext_trig_en && start_fall) begin
			d.st = ST_RUN;
			d.blk = '0;
		end

		if (abort) begin
			d.st = ST_IDLE;
			d.pend = 1'b0;
		end else if (scan_start) begin
			if (q.st == ST_IDLE) begin
				d.ptr = '0;
				d.sub = 2'h0;
				d.board = 2'h0;
				d.fresh = 1'b0;
				d.pend = 1'b0;
				d.wr = '0;
				d.rd = '0;
				d.level = '0;
				d.left = '0;
				d.total = '0;
				d.blk = '0;
				d.prev_ok = 1'b0;
				d.overrun = 1'b0;
				d.status = STATUS_IDLE;
				d.st = (ext_trig_en || analog_trig_en) ? ST_WAIT : ST_RUN;
			end else begin
				d.refused = 1'b1;
			end
		end
		d.busy = (d.st != ST_IDLE);
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			q <= '0;
			q.st <= ST_IDLE;
			q.div <= DIV_RESET;
			q.status <= STATUS_IDLE;
		end else begin
			q <= d;
		end
	end

	assign conv_start = q.conv;
	assign mux_chan = entry.chan;
	assign mux_gain = entry.gain;
	assign expander_sel = {q.board, q.sub};
	assign busy = q.busy;
	assign status = q.status;
	assign overrun = q.overrun;
	assign start_refused = q.refused;
	assign fetch_refused = q.fetch_refused;
	assign fill_level = q.level;
	assign fetch_valid = q.rvalid;
	assign fetch_data = smp.rdata;

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	a_start_refused: assert property (scan_start && !acquisition_abort && !ring_acquisition_abort
		&& (q.st != ST_IDLE) && !conv_done && !stop_fall |=> start_refused && busy)
		else $error("start accepted while busy");
	a_idle_no_store: assert property ((q.st == ST_IDLE) |-> !smp.we)
		else $error("sample stored while idle");
	a_done_status: assert property (smp.we && !ring_mode && !pretrig_en && (q.st == ST_RUN)
		&& (q.total == sample_count - 32'h1) && !acquisition_abort && !ring_acquisition_abort && !scan_start
		|=> (status == STATUS_DONE) && !busy) else $error("completion not reported");
	a_soft_start: assert property (scan_start && (q.st == ST_IDLE) && !ext_trig_en && !analog_trig_en
		&& !acquisition_abort && !ring_acquisition_abort |=> (q.st == ST_RUN) ##1 (q.st != ST_WAIT))
		else $error("software trigger missing");
	a_wait_no_store: assert property ((q.st == ST_WAIT) |-> !smp.we)
		else $error("sample stored before trigger");
	a_ptr_reset: assert property (scan_start && (q.st == ST_IDLE) && !acquisition_abort
		&& !ring_acquisition_abort |=> (q.ptr == '0) && (fill_level == '0))
		else $error("start did not rewind table");
	a_ring_wrap: assert property (smp.we && (q.wr == {BUF_AW{1'b1}}) |=> (q.wr == '0))
		else $error("ring write did not wrap");
	a_overrun_flag: assert property (smp.we && ring_mode && (q.level == BUF_DEPTH) && (q.left == '0)
		&& !scan_start |=> overrun && (fill_level == BUF_DEPTH)) else $error("overrun missed");
	a_ext_block: assert property ((q.st == ST_WAIT) && ext_trig_en && start_fall && !acquisition_abort
		&& !ring_acquisition_abort |=> (q.st == ST_RUN)) else $error("edge did not start block");
	a_fetch_stream: assert property (block_fetch && (q.left == '0) && (fetch_len == 11'h002)
		&& (q.level >= 11'h002) |=> !fetch_valid ##1 fetch_valid [*2] ##1 !fetch_valid)
		else $error("fetch length wrong");
	a_continuous: assert property (ring_mode && continuous && busy && !acquisition_abort
		&& !ring_acquisition_abort |=> busy) else $error("continuous run stopped");
	a_conv_pulse: assert property (conv_start |=> !conv_start)
		else $error("convert pulse too long");
endmodule

// ### testbench/converter_model.sv
module converter_model import scan_pkg::*; (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic conv_start,
	input wire logic [CHAN_W-1:0] mux_chan,
	input wire logic [GAIN_W-1:0] mux_gain,
	input wire logic [3:0] expander_sel,
	input wire logic [7:0] lat,
	output logic conv_done,
	output logic [DATA_W-1:0] conv_data
);
	timeunit 1ns;
	timeprecision 100ps;
	logic pend_q;
	logic [7:0] cnt_q;
	logic [DATA_W-1:0] word_q;

	// Result word names the entry converted; the data line toggles while released
	always_ff @(posedge ref_clk) begin
		conv_done <= 1'b0;
		conv_data <= ~conv_data;
		if (!resetn) begin
			pend_q <= 1'b0;
			conv_data <= '0;
		end else if (conv_start) begin
			pend_q <= 1'b1;
			cnt_q <= lat;
			word_q <= {expander_sel, mux_chan, 5'h00, mux_gain};
		end else if (pend_q && cnt_q == 8'h00) begin
			pend_q <= 1'b0;
			conv_done <= 1'b1;
			conv_data <= word_q;
		end else if (pend_q) begin
			cnt_q <= cnt_q - 8'h01;
		end
	end
endmodule

// ### testbench/tb_scan_sequencer.sv
module tb_scan_sequencer import scan_pkg::*; ;
timeunit 1ns;
timeprecision 100ps;
logic ref_clk = 0, resetn = 0, tbl_we = 0, ring_mode = 0, continuous = 0, ext_trig_en = 0, ext_conv_en = 0;
logic pretrig_en = 0, scan_start = 0, acquisition_abort = 0, ring_acquisition_abort = 0, block_fetch = 0;
logic start_trigger_n = 1, stop_trigger_n = 1, ext_convert_n = 1, conv_done, conv_start, busy, overrun;
logic start_refused, fetch_refused, fetch_valid, seen;
logic [TAB_AW-1:0] tbl_addr = '0;
logic [CHAN_W-1:0] tbl_chan = '0, mux_chan;
logic [GAIN_W-1:0] tbl_gain = '0, mux_gain;
logic [TAB_AW:0] scan_length = 10'h001;
logic [2:0] expander_board_count = 3'h0;
logic [DATA_W-1:0] conv_data, fetch_data;
logic [31:0] sample_count = '0;
logic [BUF_AW:0] block_len = 11'h001, fetch_len = 11'h001, fill_level;
logic [15:0] post_count = 16'h0000, sample_interval = 16'h0004;
logic analog_trig_en = 0, trig_rising = 1;
logic [CHAN_W-1:0] trig_chan = '0;
logic [DATA_W-1:0] trig_level = '0;
logic [3:0] expander_sel;
logic [1:0] status;
logic [7:0] lat = 8'h03;
logic [CHAN_W-1:0] ch [16];
logic [GAIN_W-1:0] gn [16];
int bad_count = 0, checks_done = 0, cyc = 0;

scan_sequencer u_scan_sequencer (.*);
converter_model u_converter_model (.*);

always #2.5 ref_clk = ~ref_clk;

always @(posedge ref_clk) begin
	cyc++;
	if (cyc == 20000) begin
		bad_count++;
		final_report();
	end
end

////////////////////////////////////////////////////////////////////////////////
task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
	checks_done++;
	if (got !== exp) begin
		bad_count++;
		$display("mismatch t=%0t %s: seen %h expected %h", $time, m, got, exp);
	end
endtask

task automatic final_report();
	$display("checks %0d mismatches %0d", checks_done, bad_count);
	if (bad_count == 0 && checks_done > 0)
		$display("TB: PASS");
	else
		$display("TB: FAIL");
	$finish;
endtask

task automatic cy(input int n);
	repeat (n) @(negedge ref_clk);
endtask

task automatic mode(input logic rm, cont, et, ec, pt, input int n, input int bl);
	@(posedge ref_clk);
	ring_mode <= rm;
	continuous <= cont;
	ext_trig_en <= et;
	ext_conv_en <= ec;
	pretrig_en <= pt;
	sample_count <= 32'(n);
	block_len <= 11'(bl);
endtask

task automatic go();
	@(posedge ref_clk);
	scan_start <= 1'b1;
	@(posedge ref_clk);
	scan_start <= 1'b0;
endtask

task automatic load(input int len);
	for (int i = 0; i < len; i++) begin
		@(posedge ref_clk);
		tbl_we <= 1'b1;
		tbl_addr <= TAB_AW'(i);
		tbl_chan <= ch[i];
		tbl_gain <= gn[i];
	end
	@(posedge ref_clk);
	tbl_we <= 1'b0;
	scan_length <= 10'(len);
endtask

task automatic wdone();
	int n = 0;
	// Let a status left over from the previous run be cleared by the start
	@(negedge ref_clk);
	while (status !== STATUS_DONE && n < 3000) begin
		@(negedge ref_clk);
		n++;
	end
	chk(status, STATUS_DONE, "status");
	chk(busy, 0, "busy after completion");
endtask

task automatic fetch(input int n, input int k0, input int len, input int brd);
	int got = 0, w = 0, k;
	@(posedge ref_clk);
	block_fetch <= 1'b1;
	fetch_len <= 11'(n);
	@(posedge ref_clk);
	block_fetch <= 1'b0;
	while (got < n && w < 60) begin
		@(negedge ref_clk);
		w++;
		k = k0 + got;
		if (fetch_valid === 1'b1) begin
			if (brd == 0)
				chk(fetch_data, {4'h0, ch[k % len], 5'h00, gn[k % len]}, "word");
			else
				chk(fetch_data, {2'h0, 2'(k % 4), ch[(k / 4) % len], 5'h00, gn[(k / 4) % len]}, "word");
			got++;
		end
	end
	chk(got, n, "words fetched");
endtask

task automatic trig();
	@(posedge ref_clk);
	start_trigger_n <= 1'b0;
	repeat (3) @(posedge ref_clk);
	start_trigger_n <= 1'b1;
endtask

////////////////////////////////////////////////////////////////////////////////
task automatic s_single();
	load(3);
	mode(0, 0, 0, 0, 0, 5, 1);
	go();
	wdone();
	chk(fill_level, 5, "stored count");
	cy(40);
	chk(fill_level, 5, "late conversions");
	fetch(5, 0, 3, 0);
	mode(0, 0, 0, 0, 0, 2, 1);
	go();
	wdone();
	fetch(2, 0, 3, 0);
endtask

task automatic s_busy();
	int n = 0;
	mode(1, 1, 0, 0, 0, 3, 4);
	go();
	cy(200);
	chk(busy, 1, "continuous run");
	chk(fill_level > 11'd4, 1, "ring past count");
	chk(overrun, 0, "no overrun");
	go();
	seen = 0;
	repeat (3) begin
		@(negedge ref_clk);
		seen |= start_refused;
	end
	chk(seen, 1, "start refused");
	while (fill_level !== BUF_DEPTH && n < 9000) begin
		@(negedge ref_clk);
		n++;
	end
	cy(40);
	chk(overrun, 1, "overrun");
	@(posedge ref_clk);
	ring_acquisition_abort <= 1'b1;
	@(posedge ref_clk);
	ring_acquisition_abort <= 1'b0;
	cy(3);
	chk(busy, 0, "ring abort");
endtask

task automatic s_trig();
	mode(1, 0, 1, 0, 0, 4, 2);
	go();
	cy(60);
	chk(fill_level, 0, "awaiting edge");
	trig();
	cy(80);
	chk(fill_level, 2, "one block");
	chk(busy, 1, "between blocks");
	trig();
	wdone();
	chk(fill_level, 4, "finite ring");
	@(posedge ref_clk);
	block_fetch <= 1'b1;
	fetch_len <= 11'h009;
	@(posedge ref_clk);
	block_fetch <= 1'b0;
	seen = 0;
	repeat (3) begin
		@(negedge ref_clk);
		seen |= fetch_refused;
	end
	chk(seen, 1, "oversize fetch");
	fetch(1, 0, 3, 0);
	fetch(3, 1, 3, 0);
endtask

task automatic s_ext_convert_n();
	mode(0, 0, 0, 1, 0, 6, 1);
	expander_board_count <= 3'h1;
	lat <= 8'd20;
	sample_interval <= 16'h0000;
	load(2);
	go();
	cy(60);
	chk(fill_level, 0, "no pacing edge");
	repeat (6) begin
		@(posedge ref_clk);
		ext_convert_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		ext_convert_n <= 1'b1;
		repeat (40) @(posedge ref_clk);
	end
	wdone();
	fetch(6, 0, 2, 1);
	@(posedge ref_clk);
	expander_board_count <= 3'h0;
	lat <= 8'h03;
	sample_interval <= 16'h0004;
endtask

task automatic s_pretrig();
	mode(0, 0, 0, 0, 1, 1000, 1);
	post_count <= 16'h0003;
	go();
	cy(100);
	chk(status, 0, "before stop edge");
	@(posedge ref_clk);
	stop_trigger_n <= 1'b0;
	repeat (3) @(posedge ref_clk);
	stop_trigger_n <= 1'b1;
	wdone();
	mode(0, 0, 0, 0, 0, 100, 1);
	go();
	cy(50);
	@(posedge ref_clk);
	acquisition_abort <= 1'b1;
	@(posedge ref_clk);
	acquisition_abort <= 1'b0;
	cy(3);
	chk(busy, 0, "abort");
	chk(status, 0, "abort is no completion");
endtask

// Rising crossing first, then falling; the gain rewrite moves the trigger channel's value
task automatic s_analog();
	load(1);
	mode(0, 0, 0, 0, 0, 2, 1);
	analog_trig_en <= 1'b1;
	trig_chan <= ch[0];
	trig_level <= {4'h0, ch[0], 5'h00, 3'h4};
	repeat (2) begin
		go();
		cy(60);
		chk(fill_level, 0, "no crossing yet");
		chk(busy, 1, "waiting for crossing");
		gn[0] = ~gn[0];
		load(1);
		wdone();
		fetch(2, 0, 1, 0);
		@(posedge ref_clk);
		trig_rising <= 1'b0;
	end
endtask

initial begin
	for (int i = 0; i < 16; i++) begin
		ch[i] = CHAN_W'((7 * i + 5) % 16);
		gn[i] = GAIN_W'(i % 8);
	end
	repeat (16) @(posedge ref_clk);
	resetn <= 1'b1;
	s_single();
	s_busy();
	s_trig();
	s_ext_convert_n();
	s_pretrig();
	s_analog();
	final_report();
end
endmodule
